// File: ssc_top.sv
// shutter status reporting, control-source selection and oscillator interlocks
`include "ssc_consts.svh"

// What this block does
// - open gives open=1 closed=0; closed gives 0,1; transition gives equal bits.
// - open and closed status sit on bits 4 and 3 of the status byte.
// - a normal transition lasts 500 to 600 ms before the final encoding.
// - abnormal shutter operation raises alarm 4065.
// - shutter overheating raises alarm 4087.
// - external-control bit 6 set: shutter follows the open request, else program command.
// - by-request bit 1 set: shutter follows request, program command drives gas only.
// - first variant opens the shutter only in the oscillation state.
// - second variant may also open the shutter in the state_a state.
// - second variant refuses oscillator start with shutter open and raises an alarm.
// - interlock input low blocks every shutter open command.
module ssc_top #(
  parameter int FAIL_CYCLES     = `SSC_FAIL_CYC,
  parameter int MOVE_MIN_CYCLES = `SSC_MOVE_MIN_CYC,
  parameter int MOVE_MAX_CYCLES = `SSC_MOVE_MAX_CYC
) (
  // clock, reset, enable
  input  wire logic                     ref_clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     ce_i,
  // register port
  input  wire ssc_pkg::ssc_reg_req_type reg_req_i,
  output logic                   [7:0]  rd_data_o,
  // discrete inputs
  input  wire ssc_pkg::ssc_pins_type    pins_i,
  // status to the ladder-logic controller
  output logic                   [7:0]  status_byte_o,
  output logic                          shutter_open_status_o,
  output logic                          shutter_closed_status_o,
  // oscillator drive
  output logic                          shutter_drive_o,
  output logic                          assist_gas_o,
  output logic                          osc_start_o,
  // alarms and interrupt
  output logic                   [11:0] alarm_code_o,
  output logic                          irq_o
);
  import ssc_pkg::*;

  ssc_pins_type         pins_s;
  ssc_pos_type          pos;
  ssc_pos_type          next_pos;
  logic           [7:0] osc_cfg;
  logic           [7:0] sht_cfg;
  logic           [7:0] variant_cfg;
  logic           [3:0] irq_status;
  logic           [3:0] irq_enable;
  logic           [3:0] irq_event;
  logic           [31:0] move_cycles;
  logic                 ext_ctrl;
  logic                 by_request;
  logic                 variant_b;
  logic                 open_cmd;
  logic                 open_allowed;
  logic                 overheat_q;
  logic                 start_q;
  logic                 start_edge;
  logic                 start_rej;
  logic                 fail_hit;
  logic                 fail_seen;
  logic                 slow_hit;
  logic                 slow_seen;
  logic                 last_fast;

  // decodes a register write to one offset
  function automatic logic wr_hit(input ssc_reg_req_type r, input logic [15:0] ofs);
    return r.wr && (r.addr == ofs);
  endfunction

  // every asynchronous pin passes the three-stage synchroniser
  ssc_sync #(
    .W ($bits(ssc_pins_type))
  ) u_sync (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .async_i   (pins_i),
    .sync_o    (pins_s)
  );

  // time spent in the moving position
  ssc_timer u_move_timer (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .run_i     (pos == SSC_MOVING),
    .count_o   (move_cycles)
  );

  // configuration registers
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      osc_cfg     <= `SSC_RST_OSC_CFG;
      sht_cfg     <= `SSC_RST_SHT_CFG;
      variant_cfg <= `SSC_RST_VARIANT_CFG;
    end else if (ce_i) begin
      if (wr_hit(reg_req_i, `SSC_OFS_OSC_CFG)) begin
        osc_cfg <= reg_req_i.wdata;
      end
      if (wr_hit(reg_req_i, `SSC_OFS_SHT_CFG)) begin
        sht_cfg <= reg_req_i.wdata;
      end
      if (wr_hit(reg_req_i, `SSC_OFS_VARIANT_CFG)) begin
        variant_cfg <= reg_req_i.wdata;
      end
    end
  end

  assign ext_ctrl   = osc_cfg[`SSC_BIT_EXT_CTRL];
  assign by_request = sht_cfg[`SSC_BIT_BY_REQUEST];
  assign variant_b  = variant_cfg[`SSC_BIT_VARIANT];

  // choose the shutter command source
  always_comb begin
    if (ext_ctrl || by_request) begin
      open_cmd = pins_s.shutter_open_request;
    end else begin
      open_cmd = pins_s.program_shutter_gas_command;
    end
  end

  // oscillator-state and interlock permission to open
  always_comb begin
    if (!pins_s.shutter_interlock_n) begin
      open_allowed = 1'b0;
    end else if (variant_b) begin
      open_allowed = pins_s.oscillation_state | pins_s.state_a;
    end else begin
      open_allowed = pins_s.oscillation_state;
    end
  end

  // shutter and assist gas drive
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      shutter_drive_o <= 1'b0;
      assist_gas_o    <= 1'b0;
    end else if (ce_i) begin
      shutter_drive_o <= open_cmd & open_allowed;
      assist_gas_o    <= pins_s.program_shutter_gas_command & ~ext_ctrl;
    end
  end

  // position decode from both sensors sampled together
  always_comb begin
    unique case ({pins_s.open_sense, pins_s.closed_sense})
      2'b10:   next_pos = SSC_OPEN;
      2'b01:   next_pos = SSC_CLOSED;
      default: next_pos = SSC_MOVING;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pos <= SSC_MOVING;
    end else if (ce_i) begin
      pos <= next_pos;
    end
  end

  // both status bits and the status byte update in the same edge
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      shutter_open_status_o   <= 1'b0;
      shutter_closed_status_o <= 1'b0;
      status_byte_o           <= 8'h00;
    end else if (ce_i) begin
      shutter_open_status_o   <= pins_s.open_sense;
      shutter_closed_status_o <= pins_s.closed_sense;
      status_byte_o                        <= 8'h00;
      status_byte_o[`SSC_BIT_OPEN_STATUS]  <= pins_s.open_sense;
      status_byte_o[`SSC_BIT_CLOSE_STATUS] <= pins_s.closed_sense;
    end
  end

  // transition timing: slow beyond the normal span, failed at one second
  assign slow_hit = (pos == SSC_MOVING) && (move_cycles == 32'(MOVE_MAX_CYCLES));
  assign fail_hit = (pos == SSC_MOVING) && (move_cycles == 32'(FAIL_CYCLES));

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      fail_seen <= 1'b0;
      slow_seen <= 1'b0;
      last_fast <= 1'b0;
    end else if (ce_i) begin
      fail_seen <= fail_hit;
      slow_seen <= slow_hit;
      // remember a transition that ended before the normal minimum
      if ((pos == SSC_MOVING) && (next_pos != SSC_MOVING)) begin
        last_fast <= (move_cycles < 32'(MOVE_MIN_CYCLES));
      end
    end
  end

  // oscillator start request and its refusal
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      start_q    <= 1'b0;
      overheat_q <= 1'b0;
    end else if (ce_i) begin
      start_q    <= pins_s.start_request;
      overheat_q <= pins_s.overheat;
    end
  end

  assign start_edge = pins_s.start_request & ~start_q;
  assign start_rej  = start_edge & variant_b & (pos == SSC_OPEN);

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      osc_start_o <= 1'b0;
    end else if (ce_i) begin
      osc_start_o <= start_edge & ~start_rej;
    end
  end

  // alarm events
  always_comb begin
    irq_event                     = 4'h0;
    irq_event[`SSC_IRQ_ACTION]    = fail_seen;
    irq_event[`SSC_IRQ_OVERHEAT]  = pins_s.overheat & ~overheat_q;
    irq_event[`SSC_IRQ_START_REJ] = start_rej;
    irq_event[`SSC_IRQ_SLOW]      = slow_seen;
  end

  // latest alarm number
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      alarm_code_o <= `SSC_ALM_NONE;
    end else if (ce_i) begin
      if (irq_event[`SSC_IRQ_OVERHEAT]) begin
        alarm_code_o <= `SSC_ALM_OVERHEAT;
      end else if (irq_event[`SSC_IRQ_ACTION]) begin
        alarm_code_o <= `SSC_ALM_ACTION;
      end else if (irq_event[`SSC_IRQ_START_REJ]) begin
        alarm_code_o <= `SSC_ALM_START_REJ;
      end
    end
  end

  // sticky status, a new event wins over a clear in the same cycle
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      irq_status <= `SSC_RST_IRQ;
    end else if (ce_i) begin
      if (wr_hit(reg_req_i, `SSC_OFS_IRQ_CLEAR)) begin
        irq_status <= (irq_status & ~reg_req_i.wdata[3:0]) | irq_event;
      end else begin
        irq_status <= irq_status | irq_event;
      end
    end
  end

  // interrupt enable register
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      irq_enable <= `SSC_RST_IRQ;
    end else if (ce_i && wr_hit(reg_req_i, `SSC_OFS_IRQ_ENABLE)) begin
      irq_enable <= reg_req_i.wdata[3:0];
    end
  end

  // level interrupt
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else if (ce_i) begin
      irq_o <= |(irq_status & irq_enable);
    end
  end

  // read data, valid in the cycle after the read strobe
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rd_data_o <= 8'h00;
    end else if (ce_i) begin
      rd_data_o <= 8'h00;
      if (reg_req_i.rd) begin
        unique case (reg_req_i.addr)
          `SSC_OFS_OSC_CFG:     rd_data_o <= osc_cfg;
          `SSC_OFS_SHT_CFG:     rd_data_o <= sht_cfg;
          `SSC_OFS_VARIANT_CFG: rd_data_o <= variant_cfg;
          `SSC_OFS_IRQ_STATUS:  rd_data_o <= {4'h0, irq_status};
          `SSC_OFS_IRQ_ENABLE:  rd_data_o <= {4'h0, irq_enable};
          `SSC_OFS_STATE:       rd_data_o <= {3'h0, last_fast, open_allowed, shutter_drive_o,
                                              shutter_open_status_o, shutter_closed_status_o};
          default:              rd_data_o <= 8'h00;
        endcase
      end
    end
  end

endmodule

// File: ssc_consts.svh
// register offsets, field positions, reset values and timing figures of the shutter block
`ifndef SSC_CONSTS_SVH
`define SSC_CONSTS_SVH

// register offsets on the plain register port
`define SSC_OFS_OSC_CFG      16'h3a99
`define SSC_OFS_SHT_CFG      16'h3a9c
`define SSC_OFS_IRQ_STATUS   16'h3aa0
`define SSC_OFS_IRQ_CLEAR    16'h3aa1
`define SSC_OFS_IRQ_ENABLE   16'h3aa2
`define SSC_OFS_VARIANT_CFG  16'h3aa3
`define SSC_OFS_STATE        16'h3aa4

// field positions
`define SSC_BIT_EXT_CTRL     6
`define SSC_BIT_BY_REQUEST   1
`define SSC_BIT_VARIANT      0
`define SSC_BIT_OPEN_STATUS  4
`define SSC_BIT_CLOSE_STATUS 3

// interrupt status layout
`define SSC_IRQ_ACTION       0
`define SSC_IRQ_OVERHEAT     1
`define SSC_IRQ_START_REJ    2
`define SSC_IRQ_SLOW         3
`define SSC_IRQ_W            4

// reset values
`define SSC_RST_OSC_CFG      8'h00
`define SSC_RST_SHT_CFG      8'h00
`define SSC_RST_VARIANT_CFG  8'h00
`define SSC_RST_IRQ          4'h0

// alarm numbers, 12 bits wide
`define SSC_ALM_NONE         12'h000
`define SSC_ALM_ACTION       12'hfe1
`define SSC_ALM_OVERHEAT     12'hff7
`define SSC_ALM_START_REJ    12'hffe

// timing figures in milliseconds, clock rate in kHz
`define SSC_CLK_KHZ          40000
`define SSC_T_MOVE_MIN_MS    500
`define SSC_T_MOVE_MAX_MS    600
`define SSC_T_FAIL_MS        1000
`define SSC_MOVE_MIN_CYC     (`SSC_T_MOVE_MIN_MS * `SSC_CLK_KHZ)
`define SSC_MOVE_MAX_CYC     (`SSC_T_MOVE_MAX_MS * `SSC_CLK_KHZ)
`define SSC_FAIL_CYC         (`SSC_T_FAIL_MS * `SSC_CLK_KHZ)

`endif

// File: ssc_pkg.sv
// types shared by the shutter status and control block
package ssc_pkg;

  // register port request
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } ssc_reg_req_type;

  // discrete inputs from the oscillator and the ladder-logic controller
  typedef struct packed {
    logic open_sense;
    logic closed_sense;
    logic overheat;
    logic shutter_interlock_n;
    logic shutter_open_request;
    logic program_shutter_gas_command;
    logic oscillation_state;
    logic state_a;
    logic start_request;
  } ssc_pins_type;

  // observed shutter position
  typedef enum logic [1:0] {
    SSC_CLOSED,
    SSC_OPEN,
    SSC_MOVING
  } ssc_pos_type;

endpackage

// File: ssc_sync.sv
// three-stage input synchroniser that accepts a change once stages two and three agree
module ssc_sync #(
  parameter int W = 1
) (
  // clock, reset, enable
  input  wire logic         ref_clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  // asynchronous in, clean out
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : gen_bit
      logic s1;
      logic s2;
      logic s3;
      // stage chain; only stage two reads stage one
      always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
        end else if (ce_i) begin
          s1 <= async_i[g];
          s2 <= s1;
          s3 <= s2;
        end
      end
      // take the level once the two later stages agree
      always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
          sync_o[g] <= 1'b0;
        end else if (ce_i && (s2 == s3)) begin
          sync_o[g] <= s3;
        end
      end
    end
  endgenerate

endmodule

// File: ssc_timer.sv
// saturating cycle counter that runs while enabled and clears when not
module ssc_timer (
  // clock, reset, enable
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // run control and elapsed count
  input  wire logic        run_i,
  output logic      [31:0] count_o
);

  // count up while running, hold at the top value
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      count_o <= 32'h0000_0000;
    end else if (ce_i) begin
      if (!run_i) begin
        count_o <= 32'h0000_0000;
      end else if (count_o != 32'hffff_ffff) begin
        count_o <= count_o + 32'h0000_0001;
      end
    end
  end

endmodule

// File: ssc_top_asserts.sv
// port checks for the shutter status and control block
module ssc_top_asserts (
  // clock, reset, enable
  input wire logic                  ref_clk_i,
  input wire logic                  rst_i,
  input wire logic                  ce_i,
  // pins and outputs
  input wire ssc_pkg::ssc_pins_type pins_i,
  input wire logic [7:0]            status_byte_o,
  input wire logic                  shutter_open_status_o,
  input wire logic                  shutter_closed_status_o,
  input wire logic                  shutter_drive_o,
  input wire logic                  osc_start_o,
  input wire logic [11:0]           alarm_code_o,
  input wire logic                  irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import ssc_pkg::*;
  default clocking cb @(posedge ref_clk_i); endclocking
  // a frozen block is not judged; the pipeline restarts when enable returns
  default disable iff (rst_i || !ce_i);
  // status byte carries the two status bits and nothing else
  a_byte_open: assert property (status_byte_o[4] == shutter_open_status_o)
    else $error("open status missing from byte bit 4");
  a_byte_closed: assert property (status_byte_o[3] == shutter_closed_status_o)
    else $error("closed status missing from byte bit 3");
  a_byte_rest: assert property (status_byte_o[7:5] == 3'h0 && status_byte_o[2:0] == 3'h0)
    else $error("stray bits in status byte");
  // a settled sensor shows on its status bit
  a_open_track: assert property ($stable(pins_i.open_sense) [*7] |->
    shutter_open_status_o == pins_i.open_sense) else $error("open status lost sensor");
  a_closed_track: assert property ($stable(pins_i.closed_sense) [*7] |->
    shutter_closed_status_o == pins_i.closed_sense) else $error("closed status lost sensor");
  // a held interlock keeps the shutter shut
  a_lock_hold: assert property (!pins_i.shutter_interlock_n [*6] |-> !shutter_drive_o)
    else $error("shutter driven open under interlock");
  // a granted start is a single pulse
  a_start_pulse: assert property (osc_start_o |=> !osc_start_o)
    else $error("start pulse too long");
  // overheat reaches the alarm code within a few cycles
  a_heat_alarm: assert property ($rose(pins_i.overheat) ##1 pins_i.overheat [*5] |->
    ##[0:4] alarm_code_o == 12'hff7) else $error("overheat alarm missing");
  // abnormal-operation alarm only appears with the shutter between positions
  a_action_cause: assert property ($rose(alarm_code_o == 12'hfe1) |->
    shutter_open_status_o == shutter_closed_status_o) else $error("action alarm while settled");
  c_refuse: cover property (alarm_code_o == 12'hffe);
  c_start: cover property (osc_start_o);
  c_irq: cover property (irq_o);
endmodule

bind ssc_top ssc_top_asserts u_ssc_top_asserts (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce_i), .pins_i(pins_i), .status_byte_o(status_byte_o),
  .shutter_open_status_o(shutter_open_status_o), .shutter_closed_status_o(shutter_closed_status_o),
  .shutter_drive_o(shutter_drive_o), .osc_start_o(osc_start_o), .alarm_code_o(alarm_code_o),
  .irq_o(irq_o)
);

// File: ssc_ladder_model.sv
// ladder-logic controller stand-in reading the status bits and driving the open request
module ssc_ladder_model #(
  parameter int FAIL = 100
) (
  // clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  // status bits, request command and verdicts
  input  wire logic       open_i,
  input  wire logic       closed_i,
  input  wire logic       cmd_i,
  output logic            req_o,
  output logic      [1:0] state_o,
  output logic            fail_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // state from both bits together: 1 open, 0 closed, 2 moving
  always_comb state_o = (open_i != closed_i) ? {1'b0, open_i} : 2'h2;
  // time spent between positions
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || state_o != 2'h2) cnt <= 0;
    else if (cnt < FAIL) cnt <= cnt + 1;
  end
  assign fail_o = (cnt >= FAIL);
  // request follows the command one scan later
  always_ff @(posedge ref_clk_i) req_o <= rst_i ? 1'b0 : cmd_i;
endmodule

// File: ssc_top_test.sv
// self-checking bench for the shutter status and control block
`include "ssc_consts.svh"
module ssc_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  import ssc_pkg::*;
  logic            ref_clk_i = 1'b0;
  logic            rst_i = 1'b1;
  logic            ce = 1'b1;
  ssc_reg_req_type req = '0;
  ssc_pins_type    pins;
  ssc_pins_type    pv;
  logic [7:0]      rd_data;
  logic [7:0]      sbyte;
  logic [7:0]      v;
  logic [31:0]     r;
  logic [11:0]     alarm;
  logic [1:0]      ll_state;
  logic            o_st, c_st, drv, gas, start, irq, cmd, ll_req, ll_fail;
  logic [7:0]      corner [3] = '{8'h9e, 8'h96, 8'h99};
  integer          seed = 68612;
  int              n_mismatch = 0;
  int              tests_run = 0;
  int              cyc = 0;
  int              npulse = 0;

  always #12.5 ref_clk_i = ~ref_clk_i;
  // open request comes from the controller model
  always_comb begin
    pv = pins;
    pv.shutter_open_request = ll_req;
  end

  ssc_top #(.FAIL_CYCLES(100), .MOVE_MIN_CYCLES(50), .MOVE_MAX_CYCLES(60)) u_ssc_top (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce), .reg_req_i(req), .rd_data_o(rd_data),
    .pins_i(pv), .status_byte_o(sbyte), .shutter_open_status_o(o_st), .shutter_closed_status_o(c_st),
    .shutter_drive_o(drv), .assist_gas_o(gas), .osc_start_o(start), .alarm_code_o(alarm), .irq_o(irq));
  ssc_ladder_model #(.FAIL(100)) u_ssc_ladder_model (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .open_i(o_st), .closed_i(c_st), .cmd_i(cmd),
    .req_o(ll_req), .state_o(ll_state), .fail_o(ll_fail));

  // pulse count and hang guard
  always @(posedge ref_clk_i) begin
    cyc++;
    if (start === 1'b1) npulse++;
    if (cyc == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task tally_and_finish;
    if (n_mismatch == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task step(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  task wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk_i) req <= '{a, d, 1'b1, 1'b0};
    @(posedge ref_clk_i) req.wr <= 1'b0;
  endtask
  task rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge ref_clk_i) req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge ref_clk_i) req.rd <= 1'b0;
    #1 chk(rd_data, e);
  endtask
  task sens(input logic o, input logic c);
    @(posedge ref_clk_i) begin
      pins.open_sense <= o;
      pins.closed_sense <= c;
    end
  endtask
  task pulse(input int e);
    int np;
    np = npulse;
    @(posedge ref_clk_i) pins.start_request <= 1'b1;
    step(8);
    chk(npulse - np, e);
    @(posedge ref_clk_i) pins.start_request <= 1'b0;
    step(6);
  endtask
  function automatic logic [7:0] f_byte(input logic o, input logic c);
    return {3'h0, o, c, 3'h0};
  endfunction
  // v: 0 ext, 1 by-request, 2 variant, 3 lock_n, 4 request, 5 program, 6 osc, 7 state_a
  function automatic logic f_drv(input logic [7:0] v);
    return ((v[0] | v[1]) ? v[4] : v[5]) & v[3] & (v[6] | (v[2] & v[7]));
  endfunction

  initial begin
    pins = 9'h0a0;
    cmd = 1'b0;
    repeat (20) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    rd(`SSC_OFS_OSC_CFG, 8'h00);
    rd(`SSC_OFS_SHT_CFG, 8'h00);
    rd(16'h3a9a, 8'h00);
    // every position encoding
    for (int i = 0; i < 4; i++) begin
      sens(i[1], i[0]);
      step(6);
      chk({o_st, c_st}, {i[1], i[0]});
      chk(sbyte, f_byte(i[1], i[0]));
    end
    sens(1'b0, 1'b1);
    step(6);
    // short transition just ended: last_fast set, shutter closed and idle
    rd(`SSC_OFS_STATE, 8'h11);
    // control source, variant and interlock, corners then random
    for (int i = 0; i < 12; i++) begin
      r = $random(seed);
      v = (i < 3) ? corner[i] : r[7:0];
      wr(`SSC_OFS_OSC_CFG, {1'b0, v[0], 6'h00});
      wr(`SSC_OFS_SHT_CFG, {6'h00, v[1], 1'b0});
      wr(`SSC_OFS_VARIANT_CFG, {7'h00, v[2]});
      @(posedge ref_clk_i) begin
        pins.shutter_interlock_n <= v[3];
        pins.program_shutter_gas_command <= v[5];
        pins.oscillation_state <= v[6];
        pins.state_a <= v[7];
        cmd <= v[4];
      end
      step(8);
      chk(drv, f_drv(v));
      chk(gas, v[5] & ~v[0]);
    end
    // start with shutter open: refused on second variant, interrupt raised, masked, cleared
    wr(`SSC_OFS_IRQ_ENABLE, 8'h04);
    wr(`SSC_OFS_VARIANT_CFG, 8'h01);
    sens(1'b1, 1'b0);
    step(6);
    pulse(0);
    chk(alarm, `SSC_ALM_START_REJ);
    chk(irq, 1'b1);
    rd(`SSC_OFS_IRQ_STATUS, 8'h04);
    wr(`SSC_OFS_IRQ_ENABLE, 8'h00);
    step(2);
    chk(irq, 1'b0);
    wr(`SSC_OFS_IRQ_CLEAR, 8'h0f);
    rd(`SSC_OFS_IRQ_STATUS, 8'h00);
    wr(`SSC_OFS_VARIANT_CFG, 8'h00);
    pulse(1);
    // stuck between positions: slow flag, then abnormal-operation alarm
    sens(1'b0, 1'b0);
    step(48);
    rd(`SSC_OFS_IRQ_STATUS, 8'h00);
    step(20);
    rd(`SSC_OFS_IRQ_STATUS, 8'h08);
    step(40);
    rd(`SSC_OFS_IRQ_STATUS, 8'h09);
    chk(alarm, `SSC_ALM_ACTION);
    chk(ll_fail, 1'b1);
    // overheat
    sens(1'b0, 1'b1);
    @(posedge ref_clk_i) pins.overheat <= 1'b1;
    step(8);
    chk(alarm, `SSC_ALM_OVERHEAT);
    rd(`SSC_OFS_IRQ_STATUS, 8'h0b);
    // long transition ended: last_fast clear, first variant permission from the last draw
    rd(`SSC_OFS_STATE, {4'h0, v[3] & v[6], f_drv({v[7:3], 1'b0, v[1:0]}), 2'b01});
    // clock enable low freezes the status outputs, release lets the sensor through
    @(posedge ref_clk_i) ce <= 1'b0;
    sens(1'b1, 1'b0);
    step(8);
    chk({o_st, c_st}, 2'b01);
    @(posedge ref_clk_i) ce <= 1'b1;
    step(6);
    chk({o_st, c_st}, 2'b10);
    tally_and_finish();
  end
endmodule
